//--- rtl/ga_annunciator.sv
// gas alarm annunciator: thresholds, latching, relays, leds, buzzer
// assumes measurements and fault flags on core_clk, keys async pins
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`include "ga_cfg.svh"
module ga_annunciator
	import ga_pkg::*;
#(
	parameter int MIN_CYC  = `GA_MINUTE_S * `GA_CLK_HZ,
	parameter int BEEP_CYC = `GA_BEEP_MS * (`GA_CLK_HZ / 1000)
)(
	input  wire logic                core_clk,
	input  wire logic                rst_b,
	input  wire logic [7:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output logic      [31:0]         avs_readdata,
	output logic                     avs_waitrequest,
	input  wire logic [3:0][11:0]    meas_val,
	input  wire logic [3:0]          clear_doubt,
	input  wire logic [3:0]          fault_det,
	input  wire logic                fault_ctrl,
	input  wire logic                fault_comm,
	input  wire logic                fault_mem,
	input  wire logic                alarm_key_b,
	input  wire logic                remote_ack_b,
	input  wire logic                mains_lost,
	input  wire logic                batt_fault,
	output logic      [4:0]          relay,
	output logic                     fail_relay,
	output logic      [3:0]          alarm_led,
	output logic                     fault_led,
	output logic                     power_led,
	output logic                     buzzer
);
	// ====================================================================
	// register file
	logic [31:0]             ctrl_ff;
	logic [11:0][31:0]       thr_ff;
	logic [3:0][31:0]        det_ff;
	logic                    ack_ff;
	logic [31:0]             rdata_ff;
	logic                    sw_ack_ff;
	logic [31:0]             nxt_rdata;
	logic                    wr_go;
	logic [7:0]              thr_off;
	logic [7:0]              det_off;
	logic [`GA_NSLOT-1:0]    lat_ff;
	logic [`GA_NSLOT-1:0]    unack_ff;
	logic [`GA_NSLOT-1:0]    buz_ff;
	logic                    fault_buz_ff;
	logic                    any_fault;
	logic [3:0]              sync1_ff;
	logic [3:0]              sync2_ff;

	// merge written bytes, reserved bits kept zero
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] msk);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		end
		be_merge = r & msk;
	endfunction

	// one wait state per access, answer when ack_ff is high
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign avs_readdata    = rdata_ff;
	assign wr_go           = avs_write & ack_ff;
	assign thr_off         = avs_address - `GA_ADR_THR_LO;
	assign det_off         = avs_address - `GA_ADR_DET_LO;

	// read mux, unmapped reads zero
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		if (avs_address == `GA_ADR_CTRL)
			nxt_rdata = ctrl_ff;
		else if (avs_address == `GA_ADR_LAT)
			nxt_rdata = {8'h00, lat_ff};
		else if (avs_address == `GA_ADR_UNACK)
			nxt_rdata = {8'h00, unack_ff};
		else if (avs_address == `GA_ADR_MISC)
			nxt_rdata = {28'h0000000, fault_buz_ff, sync2_ff[3], sync2_ff[2], any_fault};
		else if (avs_address >= `GA_ADR_THR_LO && avs_address <= `GA_ADR_THR_HI
			&& avs_address[1:0] == 2'h0)
			nxt_rdata = thr_ff[thr_off[5:2]];
		else if (avs_address >= `GA_ADR_DET_LO && avs_address <= `GA_ADR_DET_HI
			&& avs_address[1:0] == 2'h0)
			nxt_rdata = det_ff[det_off[3:2]];
	end

	// bus handshake and read data
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end
		else
		begin
			ack_ff <= (avs_read | avs_write) & ~ack_ff;
			if (avs_read & ~ack_ff)
				rdata_ff <= nxt_rdata;
		end
	end

	// configuration writes, software acknowledge pulse
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl_ff   <= `GA_CTL_RST;
			thr_ff    <= {12{`GA_THR_RST}};
			det_ff    <= {4{`GA_DET_RST}};
			sw_ack_ff <= 1'b0;
		end
		else
		begin
			sw_ack_ff <= 1'b0;
			if (wr_go && avs_address == `GA_ADR_CTRL)
			begin
				ctrl_ff   <= be_merge(ctrl_ff, avs_writedata, avs_byteenable, `GA_CTL_WMASK);
				sw_ack_ff <= avs_byteenable[0] & avs_writedata[`GA_CTL_SW_ACK];
			end
			if (wr_go && avs_address >= `GA_ADR_THR_LO && avs_address <= `GA_ADR_THR_HI
				&& avs_address[1:0] == 2'h0)
				thr_ff[thr_off[5:2]] <= be_merge(thr_ff[thr_off[5:2]], avs_writedata,
					avs_byteenable, `GA_THR_WMASK);
			if (wr_go && avs_address >= `GA_ADR_DET_LO && avs_address <= `GA_ADR_DET_HI
				&& avs_address[1:0] == 2'h0)
				det_ff[det_off[3:2]] <= be_merge(det_ff[det_off[3:2]], avs_writedata,
					avs_byteenable, `GA_DET_WMASK);
		end
	end

	// ====================================================================
	// pin synchronisers and acknowledge
	logic [1:0] key_q_ff;
	logic       ack_evt;

	// two flops, then edge detect on second stage
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1_ff <= 4'h3;
			sync2_ff <= 4'h3;
			key_q_ff <= 2'h3;
		end
		else
		begin
			sync1_ff <= {batt_fault, mains_lost, remote_ack_b, alarm_key_b};
			sync2_ff <= sync1_ff;
			key_q_ff <= sync2_ff[1:0];
		end
	end

	// front key and remote input act the same
	assign ack_evt = (|(key_q_ff & ~sync2_ff[1:0])) | sw_ack_ff;

	// ====================================================================
	// time base: minute tick, beep and blink divider
	logic [31:0] min_cnt_ff;
	logic        min_tick;
	logic [31:0] beep_cnt_ff;
	logic [2:0]  phase_ff;

	assign min_tick = (min_cnt_ff == 32'(MIN_CYC - 1));

	// free running dividers
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			min_cnt_ff  <= 32'h0000_0000;
			beep_cnt_ff <= 32'h0000_0000;
			phase_ff    <= 3'h0;
		end
		else
		begin
			min_cnt_ff <= min_tick ? 32'h0000_0000 : min_cnt_ff + 32'h0000_0001;
			if (beep_cnt_ff == 32'(BEEP_CYC - 1))
			begin
				beep_cnt_ff <= 32'h0000_0000;
				phase_ff    <= phase_ff + 3'h1;
			end
			else
				beep_cnt_ff <= beep_cnt_ff + 32'h0000_0001;
		end
	end

	// ====================================================================
	// averaging: moving average stepped every window/16 minutes
	logic [8:0] step_cnt_ff;
	logic [8:0] step_len;
	logic       avg_step;
	logic [3:0][11:0] avg_ff;

	assign step_len = (ctrl_ff[`GA_CTL_WIN] + `GA_WIN_ROUND) >> `GA_EMA_SHIFT;
	assign avg_step = min_tick && (step_cnt_ff + 9'h001 >= step_len);

	// step counter in minutes
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			step_cnt_ff <= 9'h000;
		else if (avg_step)
			step_cnt_ff <= 9'h000;
		else if (min_tick)
			step_cnt_ff <= step_cnt_ff + 9'h001;
	end

	// per detector average
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			avg_ff <= '0;
		else if (avg_step)
		begin
			for (int d = 0; d < `GA_NDET; d++)
				avg_ff[d] <= avg_ff[d] + 12'(($signed({1'b0, meas_val[d]})
					- $signed({1'b0, avg_ff[d]})) >>> `GA_EMA_SHIFT);
		end
	end

	// ====================================================================
	// threshold compare with hysteresis
	function automatic logic trip(input logic [11:0] v, input logic [11:0] lvl,
		input logic fall, input logic on, input logic [1:0] h);
		logic [12:0] hy;
		hy = 13'(h) * `GA_HYST_STEP;
		if (fall)
			trip = on ? ({1'b0, v} <= {1'b0, lvl} + hy) : (v <= lvl);
		else
			trip = on ? ({1'b0, v} + hy >= {1'b0, lvl}) : (v >= lvl);
	endfunction

	logic [`GA_NSLOT-1:0] cond_ff;
	logic [`GA_NSLOT-1:0] nxt_cond;
	logic [`GA_NSLOT-1:0] manual;

	// six alarm slots per detector: three thresholds, over, under, doubt
	genvar gd;
	genvar gk;
	generate
		for (gd = 0; gd < `GA_NDET; gd++)
		begin : g_det
			for (gk = 0; gk < 3; gk++)
			begin : g_thr
				localparam int S = gd * `GA_SLOTS_DET + gk;
				logic [31:0] c;
				logic        ti;
				logic        ta;
				assign c  = thr_ff[gd * 3 + gk];
				assign ti = trip(meas_val[gd], c[`GA_THR_LVL], c[`GA_THR_FALL], cond_ff[S],
					c[`GA_THR_HYST]);
				assign ta = trip(avg_ff[gd], c[`GA_THR_LVL], c[`GA_THR_FALL], cond_ff[S],
					c[`GA_THR_HYST]);
				// instant, averaged or either
				assign nxt_cond[S] = (c[`GA_THR_EVAL] == GA_EVAL_INST) ? ti :
					(c[`GA_THR_EVAL] == GA_EVAL_AVG) ? ta : (ti | ta);
				assign manual[S]   = c[`GA_THR_MAN];
			end
			assign nxt_cond[gd*`GA_SLOTS_DET+3] = meas_val[gd] > det_ff[gd][`GA_DET_OVR];
			assign nxt_cond[gd*`GA_SLOTS_DET+4] = meas_val[gd] < det_ff[gd][`GA_DET_UDR];
			assign nxt_cond[gd*`GA_SLOTS_DET+5] = clear_doubt[gd];
			assign manual[gd*`GA_SLOTS_DET+5 -: 3] = 3'h0;
		end
	endgenerate

	// ====================================================================
	// per slot latch: lat drives normal relay and led, unack buzzer relay
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cond_ff  <= '0;
			lat_ff   <= '0;
			unack_ff <= '0;
			buz_ff   <= '0;
		end
		else
		begin
			cond_ff <= nxt_cond;
			for (int s = 0; s < `GA_NSLOT; s++)
			begin
				// new alarm wins over a coinciding acknowledge
				if (nxt_cond[s] & ~cond_ff[s])
				begin
					lat_ff[s]   <= 1'b1;
					unack_ff[s] <= 1'b1;
					buz_ff[s]   <= 1'b1;
				end
				else if (manual[s])
				begin
					lat_ff[s]   <= lat_ff[s] & (nxt_cond[s] | (unack_ff[s] & ~ack_evt));
					unack_ff[s] <= unack_ff[s] & ~ack_evt;
					buz_ff[s]   <= buz_ff[s] & ~ack_evt;
				end
				else
				begin
					lat_ff[s]   <= nxt_cond[s];
					unack_ff[s] <= unack_ff[s] & ~ack_evt & nxt_cond[s];
					buz_ff[s]   <= buz_ff[s] & ~ack_evt;
				end
			end
		end
	end

	// ====================================================================
	// faults
	logic fault_q_ff;

	assign any_fault = fault_ctrl | fault_comm | fault_mem | (|fault_det);

	// buzzer request on a new failure, silenced by acknowledge
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fault_q_ff   <= 1'b0;
			fault_buz_ff <= 1'b0;
		end
		else
		begin
			fault_q_ff <= any_fault;
			if (any_fault & ~fault_q_ff)
				fault_buz_ff <= 1'b1;
			else if (ack_evt)
				fault_buz_ff <= 1'b0;
		end
	end

	// ====================================================================
	// relay mapping and led / buzzer composition
	logic [4:0] nxt_relay;
	logic [3:0] nxt_led;
	logic       lvl3;
	logic       lvl2;
	logic       tone;
	logic       blink;

	assign blink = phase_ff[2];

	// each relay: normal type follows lat, buzzer type follows unack
	always_comb
	begin
		nxt_relay = 5'h00;
		nxt_led   = 4'h0;
		lvl3      = 1'b0;
		lvl2      = 1'b0;
		for (int d = 0; d < `GA_NDET; d++)
		begin
			for (int k = 0; k < `GA_SLOTS_DET; k++)
			begin
				for (int r = 0; r < 5; r++)
				begin
					if ((k < 3 ? thr_ff[d*3+(k%3)][18+r] : det_ff[d][24+r])
						&& (ctrl_ff[4+r] ? unack_ff[d*6+k] : lat_ff[d*6+k]))
						nxt_relay[r] = 1'b1;
				end
				// manual unacknowledged blinks, otherwise steady
				if (lat_ff[d*6+k])
					nxt_led[d] = nxt_led[d] | ~(manual[d*6+k] & unack_ff[d*6+k]) | blink;
			end
			lvl3 = lvl3 | buz_ff[d*6+2] | buz_ff[d*6+3] | buz_ff[d*6+5];
			lvl2 = lvl2 | buz_ff[d*6+1];
		end
	end

	// faster repetition for higher levels
	assign tone = lvl3 ? phase_ff[0] : lvl2 ? phase_ff[1] : phase_ff[2];

	// registered outputs
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			relay      <= 5'h00;
			fail_relay <= 1'b0;
			alarm_led  <= 4'h0;
			fault_led  <= 1'b0;
			power_led  <= 1'b0;
			buzzer     <= 1'b0;
		end
		else
		begin
			relay      <= nxt_relay;
			fail_relay <= any_fault;
			alarm_led  <= nxt_led;
			fault_led  <= ctrl_ff[`GA_CTL_MAINT] ? blink : any_fault;
			power_led  <= (sync2_ff[2] | sync2_ff[3]) ? blink : 1'b1;
			buzzer     <= ((|buz_ff) | fault_buz_ff) & ~ctrl_ff[`GA_CTL_BUZ_OFF] & tone;
		end
	end
endmodule

//--- rtl/ga_cfg.svh
// constants for the gas alarm annunciator: register map, fields, timing
// assumes inclusion by ga_pkg users; definitions only
`ifndef GA_CFG_SVH
`define GA_CFG_SVH
// ====================================================================
// geometry
`define GA_NDET        4
`define GA_NSLOT       24
`define GA_SLOTS_DET   6
// ====================================================================
// register byte addresses
`define GA_ADR_CTRL    8'h00
`define GA_ADR_LAT     8'h04
`define GA_ADR_UNACK   8'h08
`define GA_ADR_MISC    8'h0c
`define GA_ADR_THR_LO  8'h10
`define GA_ADR_THR_HI  8'h3c
`define GA_ADR_DET_LO  8'h40
`define GA_ADR_DET_HI  8'h4c
// ====================================================================
// control fields
`define GA_CTL_BUZ_OFF 0
`define GA_CTL_MAINT   1
`define GA_CTL_SW_ACK  2
`define GA_CTL_BMODE   8:4
`define GA_CTL_WIN     24:16
`define GA_CTL_WMASK   32'h01ff_01f3
`define GA_CTL_RST     32'h000f_0000
// threshold word fields
`define GA_THR_LVL     11:0
`define GA_THR_FALL    12
`define GA_THR_EVAL    14:13
`define GA_THR_HYST    16:15
`define GA_THR_MAN     17
`define GA_THR_RLY     22:18
`define GA_THR_WMASK   32'h007f_ffff
`define GA_THR_RST     32'h0000_0fff
// detector word fields
`define GA_DET_OVR     11:0
`define GA_DET_UDR     23:12
`define GA_DET_RLY     28:24
`define GA_DET_WMASK   32'h1fff_ffff
`define GA_DET_RST     32'h0000_0fff
// ====================================================================
// timing and scaling
`define GA_CLK_HZ      25000000
`define GA_MINUTE_S    60
`define GA_BEEP_MS     125
`define GA_HYST_STEP   13'h0029
`define GA_WIN_ROUND   9'h00f
`define GA_EMA_SHIFT   4
`endif

//--- rtl/ga_pkg.sv
// types shared by the gas alarm annunciator
// assumes ga_cfg.svh for the numeric constants
package ga_pkg;
	// one detector measurement, full scale = all ones
	typedef logic [11:0] ga_meas_t;
	// evaluation source of a threshold alarm
	typedef enum logic [1:0] {GA_EVAL_INST, GA_EVAL_AVG, GA_EVAL_BOTH} ga_eval_t;
endpackage

//--- tb/ga_annunciator_sva.sv
// port level checker for the gas alarm annunciator
// assumes core_clk with active-low rst_b, bench keeps faults low in reset
`timescale 1ns/10ps
module ga_annunciator_sva
	import ga_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst_b,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic [3:0] fault_det,
	input wire logic       fault_ctrl,
	input wire logic       fault_comm,
	input wire logic       fault_mem,
	input wire logic       alarm_key_b,
	input wire logic       remote_ack_b,
	input wire logic       mains_lost,
	input wire logic       batt_fault,
	input wire logic [4:0] relay,
	input wire logic       fail_relay,
	input wire logic       buzzer,
	input wire logic       power_led
);
	// any failure present
	logic any_fail;
	assign any_fail = (|fault_det) | fault_ctrl | fault_comm | fault_mem;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// ==========================================================
	// assertions
	AST_FAIL_ON: assert property (any_fail |=> fail_relay)
		else $error("failure relay missed a failure");
	AST_FAIL_OFF: assert property (!any_fail |=> !fail_relay)
		else $error("failure relay on with no failure");
	AST_POWER_OK: assert property ((!mains_lost && !batt_fault) [*4] |=> power_led)
		else $error("power led not steady on good supply");
	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer not after one wait state");
	AST_WAIT_IDLE: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("waitrequest high without a request");
	AST_KEY_ACK: assert property ($fell(alarm_key_b) |-> ##8 !buzzer [*8])
		else $error("reset key did not silence buzzer");
	AST_REMOTE_ACK: assert property ($fell(remote_ack_b) |-> ##8 !buzzer [*8])
		else $error("remote acknowledge did not silence buzzer");
	AST_FAULT_BUZ: assert property ($rose(any_fail) |-> ##[1:40] buzzer)
		else $error("buzzer silent on new failure");

	// ==========================================================
	// covers
	COV_FAIL: cover property ($rose(fail_relay));
	COV_RELAY: cover property (relay == 5'h03);
	COV_BUS: cover property ((avs_read || avs_write) && !avs_waitrequest);
endmodule

bind ga_annunciator ga_annunciator_sva u_sva (
	.core_clk        (core_clk),
	.rst_b           (rst_b),
	.avs_read        (avs_read),
	.avs_write       (avs_write),
	.avs_waitrequest (avs_waitrequest),
	.fault_det       (fault_det),
	.fault_ctrl      (fault_ctrl),
	.fault_comm      (fault_comm),
	.fault_mem       (fault_mem),
	.alarm_key_b     (alarm_key_b),
	.remote_ack_b    (remote_ack_b),
	.mains_lost      (mains_lost),
	.batt_fault      (batt_fault),
	.relay           (relay),
	.fail_relay      (fail_relay),
	.buzzer          (buzzer),
	.power_led       (power_led)
);

//--- tb/ga_det_model.sv
// detector channels, fault flags, supply pins and acknowledge keys
// assumes the bench calls its tasks; keys idle high by pull-up
`timescale 1ns/10ps
module ga_det_model
	import ga_pkg::*;
(
	input  wire logic             core_clk,
	output logic      [3:0][11:0] meas_val,
	output logic      [3:0]       clear_doubt,
	output logic      [3:0]       fault_det,
	output logic                  fault_ctrl,
	output logic                  fault_comm,
	output logic                  fault_mem,
	output logic                  alarm_key_b,
	output logic                  remote_ack_b,
	output logic                  mains_lost,
	output logic                  batt_fault
);
	// idle: no gas, no failure, good supply, keys released
	initial
	begin
		meas_val = '0;
		clear_doubt = '0;
		{fault_mem, fault_comm, fault_ctrl, fault_det} = '0;
		{batt_fault, mains_lost} = '0;
		alarm_key_b = 1'b1;
		remote_ack_b = 1'b1;
	end

	// new measurement on one channel
	task meas(input int d, input logic [11:0] v);
		@(posedge core_clk);
		meas_val[d] <= v;
	endtask

	// failure flags {mem, comm, ctrl, det[3:0]}
	task fault(input logic [6:0] v);
		@(posedge core_clk);
		{fault_mem, fault_comm, fault_ctrl, fault_det} <= v;
	endtask

	// clear-doubt condition per detector
	task doubt(input logic [3:0] v);
		@(posedge core_clk);
		clear_doubt <= v;
	endtask

	// supply pins {battery, mains}
	task power(input logic [1:0] v);
		@(posedge core_clk);
		{batt_fault, mains_lost} <= v;
	endtask

	// key press held long enough for the synchroniser
	task ack(input logic remote);
		@(posedge core_clk);
		if (remote)
			remote_ack_b <= 1'b0;
		else
			alarm_key_b <= 1'b0;
		repeat (6) @(posedge core_clk);
		alarm_key_b <= 1'b1;
		remote_ack_b <= 1'b1;
	endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the gas alarm annunciator
// assumes short minute and beep parameters, detector model beside the dut
`timescale 1ns/10ps
module testbench
	import ga_pkg::*;
;
	logic             core_clk;
	logic             rst_b;
	logic [7:0]       avs_address;
	logic             avs_read;
	logic             avs_write;
	logic [31:0]      avs_writedata;
	logic [3:0]       avs_byteenable;
	wire  [31:0]      avs_readdata;
	wire              avs_waitrequest;
	wire  [3:0][11:0] meas_val;
	wire  [3:0]       clear_doubt;
	wire  [3:0]       fault_det;
	wire              fault_ctrl, fault_comm, fault_mem;
	wire              alarm_key_b, remote_ack_b, mains_lost, batt_fault;
	wire  [4:0]       relay;
	wire  [3:0]       alarm_led;
	wire              fail_relay, fault_led, power_led, buzzer;
	int               bad_count;
	int               n_tests;
	logic [31:0]      q;

	ga_annunciator #(.MIN_CYC(20), .BEEP_CYC(4)) u_dut (.core_clk, .rst_b, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .meas_val, .clear_doubt, .fault_det, .fault_ctrl, .fault_comm,
		.fault_mem, .alarm_key_b, .remote_ack_b, .mains_lost, .batt_fault, .relay,
		.fail_relay, .alarm_led, .fault_led, .power_led, .buzzer);
	ga_det_model u_det (.core_clk, .meas_val, .clear_doubt, .fault_det, .fault_ctrl,
		.fault_comm, .fault_mem, .alarm_key_b, .remote_ack_b, .mains_lost, .batt_fault);

	// ==========================================================
	// clock
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// ==========================================================
	// helpers
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// one avalon transfer, held until waitrequest is sampled low at a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be = 4'hf);
		int i;
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_byteenable <= be;
		i = 0;
		do
		begin
			@(posedge core_clk);
			i++;
		end
		while (avs_waitrequest !== 1'b0 && i < 20);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0)
		begin
			bad_count++;
			give_verdict;
		end
	endtask

	// move one channel and check the relays after the pipeline
	task mv(input int d, input logic [11:0] v, input logic [4:0] r);
		u_det.meas(d, v);
		repeat (4) @(posedge core_clk);
		chk("relay", relay, r);
	endtask

	// press a key and check the relays afterwards
	task ak(input logic remote, input logic [4:0] r);
		u_det.ack(remote);
		repeat (4) @(posedge core_clk);
		chk("relay after ack", relay, r);
	endtask

	// watch an output: 10 steady on, 01 off, 11 blinking or sounding
	task look(input int sel, input logic [1:0] exp, input string nm);
		logic [1:0] saw;
		logic       v;
		saw = 2'b00;
		repeat (4) @(posedge core_clk);
		repeat (48)
		begin
			@(negedge core_clk);
			case (sel)
				0: v = buzzer;
				1: v = alarm_led[0];
				2: v = fault_led;
				default: v = power_led;
			endcase
			saw[v === 1'b1] = 1'b1;
		end
		chk(nm, saw, exp);
	endtask

	// count buzzer changes over 32 cycles: a fast tone changes often
	task rate(input logic exp, input string nm);
		int   n;
		logic p;
		n = 0;
		p = buzzer;
		repeat (32)
		begin
			@(negedge core_clk);
			if (buzzer !== p)
				n++;
			p = buzzer;
		end
		chk(nm, n > 4, exp);
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		rst_b = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hf;
		bad_count = 0;
		n_tests = 0;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		bus(0, 8'h00, 32'h0);
		chk("ctrl reset", q, 32'h000f_0000);
		bus(0, 8'h10, 32'h0);
		chk("threshold reset", q, 32'h0000_0fff);
		bus(1, 8'h50, 32'hffff_ffff);
		bus(0, 8'h50, 32'h0);
		chk("unmapped", q, 32'h0);
		look(3, 2'b10, "power steady");
		// auto release, rising, relay 1 of buzzer type
		bus(1, 8'h00, 32'h000f_0020);
		bus(1, 8'h10, 32'h000c_0800);
		mv(0, 12'h7ff, 5'h00);
		mv(0, 12'h800, 5'h03);
		look(1, 2'b10, "led steady");
		look(0, 2'b11, "buzzer on");
		ak(0, 5'h01);
		look(0, 2'b01, "buzzer acked");
		mv(0, 12'h000, 5'h00);
		mv(0, 12'h900, 5'h03);
		mv(0, 12'h000, 5'h00);
		look(0, 2'b11, "buzzer held");
		ak(1, 5'h00);
		look(0, 2'b01, "buzzer remote acked");
		// manual release
		bus(1, 8'h10, 32'h000e_0800);
		mv(0, 12'h800, 5'h03);
		look(1, 2'b11, "led blink");
		mv(0, 12'h000, 5'h03);
		ak(0, 5'h00);
		look(1, 2'b01, "led cleared");
		mv(0, 12'h800, 5'h03);
		ak(0, 5'h01);
		look(1, 2'b10, "led steady after ack");
		mv(0, 12'h000, 5'h00);
		// falling with one percent hysteresis on detector 1
		u_det.meas(1, 12'h500);
		bus(1, 8'h20, 32'h0004_9400);
		mv(1, 12'h400, 5'h01);
		mv(1, 12'h429, 5'h01);
		mv(1, 12'h42a, 5'h00);
		u_det.ack(0);
		// buzzer disabled
		bus(1, 8'h00, 32'h000f_0021);
		mv(0, 12'h800, 5'h03);
		look(0, 2'b01, "buzzer disabled");
		ak(0, 5'h01);
		mv(0, 12'h000, 5'h00);
		bus(1, 8'h00, 32'h000f_0020);
		// byte lanes, then clear-doubt and over-range alarms on detector 3
		bus(1, 8'h14, 32'hffff_ff78, 4'h1);
		bus(0, 8'h14, 32'h0);
		chk("byte lane", q, 32'h0000_0f78);
		bus(1, 8'h4c, 32'h1000_0800);
		u_det.doubt(4'h8);
		repeat (4) @(posedge core_clk);
		chk("doubt relay", relay, 5'h10);
		u_det.doubt(4'h0);
		repeat (4) @(posedge core_clk);
		chk("doubt auto", relay, 5'h00);
		mv(3, 12'h801, 5'h10);
		rate(1'b1, "fast tone");
		mv(3, 12'h000, 5'h00);
		ak(0, 5'h00);
		look(0, 2'b01, "over acked");
		mv(0, 12'h800, 5'h03);
		rate(1'b0, "slow tone");
		ak(0, 5'h01);
		mv(0, 12'h000, 5'h00);
		// averaged threshold on detector 2 lags the instant value
		bus(1, 8'h28, 32'h0010_21f0);
		u_det.meas(2, 12'hfff);
		repeat (4) @(posedge core_clk);
		chk("avg not instant", relay, 5'h00);
		repeat (80) @(posedge core_clk);
		chk("avg relay", relay, 5'h04);
		bus(1, 8'h28, 32'h0010_2fff);
		ak(1, 5'h00);
		mv(2, 12'h000, 5'h00);
		// failures
		u_det.fault(7'h04);
		look(2, 2'b10, "fault led steady");
		chk("fail relay", fail_relay, 1'b1);
		u_det.ack(0);
		u_det.fault(7'h70);
		look(0, 2'b01, "fault buzzer acked");
		u_det.fault(7'h00);
		look(2, 2'b01, "fault led clear");
		chk("fail relay clear", fail_relay, 1'b0);
		bus(1, 8'h00, 32'h000f_0022);
		look(2, 2'b11, "fault led blink");
		u_det.power(2'b01);
		look(3, 2'b11, "power blink mains");
		u_det.power(2'b10);
		look(3, 2'b11, "power blink battery");
		give_verdict;
	end
endmodule
